/* File: rtl/hbp_consts.svh */
// Purpose: Constants shared by both ends of the byte-wide host port
// Assumes: 20 MHz system clock on both ends
// Notes: Control and status bit positions, reset values, host timing
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH

`define HBP_CTL_WIDTH_BIT 0
`define HBP_CTL_PROTO_BIT 1
`define HBP_CTL_DSLVL_BIT 2
`define HBP_CTL_BSPOL_BIT 3
`define HBP_CTL_FLAGPOL_BIT 4
`define HBP_CTL_MERGE_BIT 5
`define HBP_CTL_EMPINV_BIT 7

`define HBP_STAT_FULL_BIT 1
`define HBP_STAT_EMPTY_BIT 0

`define HBP_CTL_RESET 8'h00
`define HBP_FULL_RESET 1'b0
`define HBP_EMPTY_RESET 1'b1
`define HBP_SYNC_RESET 15'h7FFF

`define HBP_CLK_MHZ 20
`define HBP_SETUP_NS 100
`define HBP_STROBE_NS 400
`define HBP_HOLD_NS 100
`define HBP_SETUP_CYC ((`HBP_SETUP_NS * `HBP_CLK_MHZ + 999) / 1000)
`define HBP_STROBE_CYC ((`HBP_STROBE_NS * `HBP_CLK_MHZ + 999) / 1000)
`define HBP_HOLD_CYC ((`HBP_HOLD_NS * `HBP_CLK_MHZ + 999) / 1000)

`endif

/* File: rtl/hbp_pkg.sv */
// Purpose: Types shared by both ends of the byte-wide host port
// Assumes: Constants come from hbp_consts.svh
// Notes: Types only
package hbp_pkg;

	typedef enum logic [1:0] {HBP_TGT_NONE, HBP_TGT_LOW, HBP_TGT_HIGH, HBP_TGT_STATUS} hbp_target_t;

	typedef enum logic [1:0] {HBP_IDLE, HBP_SETUP, HBP_STROBE, HBP_HOLD} hbp_host_state_t;

endpackage

/* File: rtl/hbp_pins_if.sv */
// Purpose: Pin bundle between the host end and the device end
// Assumes: Host drives every strobe; device never drives strobes
// Notes: Data lines resolved here from both enables; idle level is all ones
interface hbp_pins_if;

	logic port_select_n;
	logic input_strobe_n;
	logic output_strobe_n;
	logic read_write_line;
	logic single_data_strobe;
	logic byte_select_pin;
	logic status_select_pin;
	logic [7:0] host_data_from_host;
	logic host_data_host_oe;
	logic [7:0] host_data_from_dev;
	logic host_data_dev_oe;
	logic [7:0] host_data_lines;
	logic input_full_pin;
	logic output_empty_pin;

	assign host_data_lines = host_data_dev_oe ? host_data_from_dev :
		(host_data_host_oe ? host_data_from_host : 8'hFF);

	modport dev (
		input port_select_n, input_strobe_n, output_strobe_n, read_write_line,
		input single_data_strobe, byte_select_pin, status_select_pin, host_data_lines,
		output host_data_from_dev, host_data_dev_oe, input_full_pin, output_empty_pin
	);

	modport host (
		output port_select_n, input_strobe_n, output_strobe_n, read_write_line,
		output single_data_strobe, byte_select_pin, status_select_pin,
		output host_data_from_host, host_data_host_oe,
		input host_data_lines, input_full_pin, output_empty_pin
	);

endinterface

/* File: rtl/hbp_device.sv */
// Purpose: Device end of the byte-wide host port, buffers, flags and status
// Assumes: All host pins are asynchronous to sys_clk_i and pass two flip-flops
// Notes: Host accesses complete on strobe release; core side is single-cycle
`include "hbp_consts.svh"

// Operation
// [RULE1] Passive eight-bit port, host makes all strobes
// [RULE2] Sixteen-bit input and output buffers
// [RULE3] Pins show input full, output empty
// [RULE4] Status readable only with status select
// [RULE5] Chip select high ignores all strobes
// [RULE6] Strobe assertion raises enabled core interrupt
// [RULE7] Control bit 0 picks sixteen-bit width
// [RULE8] Byte select polarity set by bit 3
// [RULE9] Sixteen-bit flags set after final byte
// [RULE10] Eight-bit mode: low byte, every access flags
// [RULE11] Control bit 1 picks strobe protocol
// [RULE12] Separate strobes are active low
// [RULE13] Single strobe level from control bit 2
// [RULE14] Control bit 4 sets flag pin polarity; the merged full pin (bit 5 set) ignores bit 4
// [RULE15] Bit 5 merges both flags onto full pin
// [RULE16] Bit 7 inverts status empty bit only
// [RULE17] Effective byte select picks buffer byte
// [RULE18] Status needs byte select matching bit 3
// [RULE19] Status byte: flags low, upper bits zero
// [RULE20] Core read/write clears full/empty flags
module hbp_device (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	hbp_pins_if.dev pins,
	input wire logic ctrl_wr_i,
	input wire logic [7:0] ctrl_data_i,
	output logic [7:0] ctrl_o,
	input wire logic out_buf_wr_i,
	input wire logic [15:0] out_buf_data_i,
	input wire logic in_buf_rd_i,
	output logic [15:0] in_buf_data_o,
	input wire logic [1:0] irq_en_i,
	output logic in_irq_o,
	output logic out_irq_o,
	output logic input_full_o,
	output logic output_empty_o,
	output logic [7:0] status_o
);

	logic [14:0] pin_raw;
	logic [14:0] pin_s1;
	logic [14:0] pin_s2;
	logic s_cs_n;
	logic s_in_n;
	logic s_out_n;
	logic s_rw;
	logic s_ds;
	logic s_bsel;
	logic s_stat;
	logic [7:0] s_data;
	logic [7:0] ctrl;
	logic width16;
	logic cs_act;
	logic ds_on;
	logic wr_act;
	logic rd_act;
	logic wr_q;
	logic rd_q;
	logic wr_done;
	logic rd_done;
	logic bs_match;
	hbp_pkg::hbp_target_t target;
	hbp_pkg::hbp_target_t target_q;
	hbp_pkg::hbp_target_t final_byte;
	logic [7:0] data_q;
	logic [15:0] in_buf;
	logic [15:0] out_buf;
	logic input_full;
	logic output_empty;
	logic set_full;
	logic set_empty;
	logic [7:0] status;
	logic [7:0] next_dev_data;
	logic full_pin_level;

	// Two-stage synchroniser for every host pin
	assign pin_raw = {pins.port_select_n, pins.input_strobe_n, pins.output_strobe_n,
		pins.read_write_line, pins.single_data_strobe, pins.byte_select_pin,
		pins.status_select_pin, pins.host_data_lines};

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pin_s1 <= `HBP_SYNC_RESET;
			pin_s2 <= `HBP_SYNC_RESET;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
		end
	end

	assign {s_cs_n, s_in_n, s_out_n, s_rw, s_ds, s_bsel, s_stat, s_data} = pin_s2;

	// Control register, written by the core
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			ctrl <= `HBP_CTL_RESET;
		else if (ctrl_wr_i)
			ctrl <= ctrl_data_i;
	end

	assign ctrl_o = ctrl;
	assign width16 = ctrl[`HBP_CTL_WIDTH_BIT]; // RULE7

	// Strobe decode; nothing is seen while chip select is high
	assign cs_act = ~s_cs_n; // RULE5 RULE1
	assign ds_on = s_ds == ctrl[`HBP_CTL_DSLVL_BIT]; // RULE13
	// RULE11 RULE12
	assign wr_act = cs_act & (ctrl[`HBP_CTL_PROTO_BIT] ? (ds_on & ~s_rw) : ~s_in_n);
	assign rd_act = cs_act & (ctrl[`HBP_CTL_PROTO_BIT] ? (ds_on & s_rw) : ~s_out_n);

	// Byte and status selection
	assign bs_match = s_bsel == ctrl[`HBP_CTL_BSPOL_BIT]; // RULE8

	always_comb
	begin
		if (s_stat)
			target = bs_match ? hbp_pkg::HBP_TGT_STATUS : hbp_pkg::HBP_TGT_NONE; // RULE4 RULE18
		else if (width16)
			target = bs_match ? hbp_pkg::HBP_TGT_LOW : hbp_pkg::HBP_TGT_HIGH; // RULE17
		else
			target = bs_match ? hbp_pkg::HBP_TGT_LOW : hbp_pkg::HBP_TGT_NONE; // RULE10 RULE18
	end

	// Byte whose completion sets a flag
	always_comb
	begin
		if (width16 && !ctrl[`HBP_CTL_BSPOL_BIT])
			final_byte = hbp_pkg::HBP_TGT_HIGH; // RULE9
		else
			final_byte = hbp_pkg::HBP_TGT_LOW; // RULE9 RULE10
	end

	// Access tracking; target and write data held from the active phase
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			target_q <= hbp_pkg::HBP_TGT_NONE;
			data_q <= 8'h00;
		end
		else
		begin
			wr_q <= wr_act;
			rd_q <= rd_act;
			if (wr_act || rd_act)
				target_q <= target;
			if (wr_act)
				data_q <= s_data;
		end
	end

	assign wr_done = wr_q & ~wr_act;
	assign rd_done = rd_q & ~rd_act;

	// Interrupt pulses on strobe assertion
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			in_irq_o <= 1'b0;
			out_irq_o <= 1'b0;
		end
		else
		begin
			in_irq_o <= wr_act & ~wr_q & irq_en_i[0]; // RULE6
			out_irq_o <= rd_act & ~rd_q & irq_en_i[1]; // RULE6
		end
	end

	// Input buffer, filled by host writes
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			in_buf <= 16'h0000;
		else if (wr_done && target_q == hbp_pkg::HBP_TGT_LOW)
			in_buf[7:0] <= data_q; // RULE2
		else if (wr_done && target_q == hbp_pkg::HBP_TGT_HIGH)
			in_buf[15:8] <= data_q; // RULE2
	end

	assign in_buf_data_o = in_buf;

	// Output buffer, filled by the core
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			out_buf <= 16'h0000;
		else if (out_buf_wr_i)
			out_buf <= out_buf_data_i; // RULE2
	end

	// Buffer flags; a host set in the same cycle as a core clear wins
	assign set_full = wr_done & (target_q == final_byte);
	assign set_empty = rd_done & (target_q == final_byte);

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			input_full <= `HBP_FULL_RESET;
			output_empty <= `HBP_EMPTY_RESET;
		end
		else
		begin
			input_full <= set_full | (input_full & ~in_buf_rd_i); // RULE20 RULE9 RULE10
			output_empty <= set_empty | (output_empty & ~out_buf_wr_i); // RULE20 RULE9 RULE10
		end
	end

	assign input_full_o = input_full;
	assign output_empty_o = output_empty;

	// Status byte
	always_comb
	begin
		status = 8'h00; // RULE19
		status[`HBP_STAT_FULL_BIT] = input_full; // RULE19
		status[`HBP_STAT_EMPTY_BIT] = output_empty ^ ctrl[`HBP_CTL_EMPINV_BIT]; // RULE16
	end

	assign status_o = status;

	// Read data onto the host lines; reserved selections leave lines undriven
	always_comb
	begin
		unique case (target)
			hbp_pkg::HBP_TGT_LOW: next_dev_data = out_buf[7:0]; // RULE17
			hbp_pkg::HBP_TGT_HIGH: next_dev_data = out_buf[15:8]; // RULE17
			hbp_pkg::HBP_TGT_STATUS: next_dev_data = status; // RULE4
			hbp_pkg::HBP_TGT_NONE: next_dev_data = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pins.host_data_from_dev <= 8'h00;
			pins.host_data_dev_oe <= 1'b0;
		end
		else
		begin
			pins.host_data_from_dev <= rd_act ? next_dev_data : 8'h00;
			pins.host_data_dev_oe <= rd_act & (target != hbp_pkg::HBP_TGT_NONE); // RULE18
		end
	end

	// Flag pins
	assign full_pin_level = ctrl[`HBP_CTL_MERGE_BIT] ? (input_full | output_empty) :
		(input_full ^ ctrl[`HBP_CTL_FLAGPOL_BIT]); // RULE15 RULE14

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pins.input_full_pin <= 1'b0;
			pins.output_empty_pin <= 1'b0;
		end
		else
		begin
			pins.input_full_pin <= full_pin_level; // RULE3
			pins.output_empty_pin <= output_empty ^ ctrl[`HBP_CTL_FLAGPOL_BIT]; // RULE3 RULE14
		end
	end

endmodule

/* File: rtl/hbp_host.sv */
// Purpose: Host end of the byte-wide host port, one byte access per command
// Assumes: proto_i and strobe_level_i match the device control bits 1 and 2
// Notes: Fixed setup, strobe and hold phases; read data sampled at strobe end
`include "hbp_consts.svh"

module hbp_host (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	hbp_pins_if.host pins,
	input wire logic proto_i,
	input wire logic strobe_level_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_write_i,
	input wire logic cmd_status_i,
	input wire logic cmd_byte_sel_i,
	input wire logic [7:0] cmd_data_i,
	output logic rsp_valid_o,
	output logic [7:0] rsp_data_o,
	output logic input_full_o,
	output logic output_empty_o
);

	localparam logic [3:0] SETUP_LAST = 4'(`HBP_SETUP_CYC - 1);
	localparam logic [3:0] STROBE_LAST = 4'(`HBP_STROBE_CYC - 1);
	localparam logic [3:0] HOLD_LAST = 4'(`HBP_HOLD_CYC - 1);

	hbp_pkg::hbp_host_state_t state;
	logic [3:0] cnt;
	logic is_write;
	logic [9:0] in_s1;
	logic [9:0] in_s2;
	logic take;
	logic step;

	assign cmd_ready_o = state == hbp_pkg::HBP_IDLE;
	assign take = cmd_valid_i & cmd_ready_o;
	assign step = cnt == 4'h0;

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			in_s1 <= 10'h000;
			in_s2 <= 10'h000;
		end
		else
		begin
			in_s1 <= {pins.host_data_lines, pins.input_full_pin, pins.output_empty_pin};
			in_s2 <= in_s1;
		end
	end

	assign input_full_o = in_s2[1];
	assign output_empty_o = in_s2[0];

	// Phase sequencer
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			state <= hbp_pkg::HBP_IDLE;
			cnt <= 4'h0;
			is_write <= 1'b0;
		end
		else
		begin
			unique case (state)
				hbp_pkg::HBP_IDLE:
					if (take)
					begin
						state <= hbp_pkg::HBP_SETUP;
						cnt <= SETUP_LAST;
						is_write <= cmd_write_i;
					end
				hbp_pkg::HBP_SETUP:
					if (step)
					begin
						state <= hbp_pkg::HBP_STROBE;
						cnt <= STROBE_LAST;
					end
					else
						cnt <= cnt - 4'h1;
				hbp_pkg::HBP_STROBE:
					if (step)
					begin
						state <= hbp_pkg::HBP_HOLD;
						cnt <= HOLD_LAST;
					end
					else
						cnt <= cnt - 4'h1;
				hbp_pkg::HBP_HOLD:
					if (step)
						state <= hbp_pkg::HBP_IDLE;
					else
						cnt <= cnt - 4'h1;
			endcase
		end
	end

	// Pin drive; strobes only during the strobe phase
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pins.port_select_n <= 1'b1;
			pins.input_strobe_n <= 1'b1;
			pins.output_strobe_n <= 1'b1;
			pins.read_write_line <= 1'b1;
			pins.single_data_strobe <= 1'b0;
			pins.byte_select_pin <= 1'b0;
			pins.status_select_pin <= 1'b0;
			pins.host_data_from_host <= 8'h00;
			pins.host_data_host_oe <= 1'b0;
		end
		else if (take)
		begin
			pins.port_select_n <= 1'b0;
			pins.read_write_line <= ~cmd_write_i;
			pins.single_data_strobe <= ~strobe_level_i;
			pins.byte_select_pin <= cmd_byte_sel_i;
			pins.status_select_pin <= cmd_status_i;
			pins.host_data_from_host <= cmd_data_i;
			pins.host_data_host_oe <= cmd_write_i;
		end
		else if (state == hbp_pkg::HBP_SETUP && step)
		begin
			pins.input_strobe_n <= ~(~proto_i & is_write);
			pins.output_strobe_n <= ~(~proto_i & ~is_write);
			pins.single_data_strobe <= proto_i ? strobe_level_i : ~strobe_level_i;
		end
		else if (state == hbp_pkg::HBP_STROBE && step)
		begin
			pins.input_strobe_n <= 1'b1;
			pins.output_strobe_n <= 1'b1;
			pins.single_data_strobe <= ~strobe_level_i;
		end
		else if (state == hbp_pkg::HBP_HOLD && step)
		begin
			pins.port_select_n <= 1'b1;
			pins.read_write_line <= 1'b1;
			pins.host_data_host_oe <= 1'b0;
		end
	end

	// Read result
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			rsp_valid_o <= 1'b0;
			rsp_data_o <= 8'h00;
		end
		else
		begin
			rsp_valid_o <= state == hbp_pkg::HBP_STROBE && step && !is_write;
			if (state == hbp_pkg::HBP_STROBE && step && !is_write)
				rsp_data_o <= in_s2[9:2];
		end
	end

endmodule

/* File: testbench/hbp_link_props.sv */
// Purpose: Pin-level checks between host end and device end
// Assumes: One clock, synchronous active-high reset
// Notes: Sees interface signals only
module hbp_link_props (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic port_select_n,
	input wire logic input_strobe_n,
	input wire logic output_strobe_n,
	input wire logic byte_select_pin,
	input wire logic [7:0] host_data_from_host,
	input wire logic host_data_host_oe,
	input wire logic host_data_dev_oe,
	input wire logic input_full_pin,
	input wire logic output_empty_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	no_contention_a: assert property (!(host_data_dev_oe && host_data_host_oe))
		else $error("data lines driven by both ends");
	strobe_needs_select_a: assert property ((!input_strobe_n || !output_strobe_n) |-> !port_select_n)
		else $error("strobe active without chip select");
	write_strobe_width_a: assert property ($fell(input_strobe_n) |-> (!input_strobe_n)[*8] ##1 input_strobe_n)
		else $error("write strobe not low for eight cycles");
	reset_pin_levels_a: assert property ($fell(reset_i) |=> !input_full_pin && output_empty_pin)
		else $error("flag pins wrong after reset");
	read_drive_start_a: assert property ($rose(host_data_dev_oe) |-> !$past(port_select_n, 2))
		else $error("device drove data without chip select");
	read_drive_end_a: assert property ($rose(output_strobe_n) |-> ##[1:5] !host_data_dev_oe)
		else $error("device kept driving after read strobe");
	write_data_stable_a: assert property ((!input_strobe_n && !$fell(input_strobe_n)) |-> $stable(host_data_from_host))
		else $error("write data changed under strobe");
	byte_select_stable_a: assert property ((!output_strobe_n && !$past(output_strobe_n)) |-> $stable(byte_select_pin))
		else $error("byte select changed under read strobe");

	cover property ($fell(input_strobe_n));
	cover property ($rose(host_data_dev_oe));
	cover property ($rose(input_full_pin));
endmodule

/* File: testbench/tb.sv */
// Purpose: Self-checking bench joining host end and device end
// Assumes: 20 MHz clock, synchronous reset held 6 cycles
// Notes: Random bytes from xorshift, corner cases by loops
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic proto = 1'b0, lvl = 1'b0, cv = 1'b0, cw = 1'b0, cs = 1'b0, cb = 1'b0;
	logic ctl_wr = 1'b0, ob_wr = 1'b0, ib_rd = 1'b0, seen = 1'b0;
	logic rdy, rv, h_full, h_empty, d_full, d_empty, in_irq, out_irq;
	logic [7:0] cd = 8'h00, ctl = 8'h00, rd, ctrl_o, status, lo, hi;
	logic [15:0] ob = 16'h0000, ib;
	logic [1:0] irq_en = 2'b00;
	logic [31:0] seed = 32'h00009BF1;
	int n_errors = 0, checks = 0, n_irq = 0;

	hbp_pins_if hbp_pins_if_i ();
	hbp_device hbp_device_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .pins(hbp_pins_if_i),
		.ctrl_wr_i(ctl_wr), .ctrl_data_i(ctl), .ctrl_o(ctrl_o), .out_buf_wr_i(ob_wr),
		.out_buf_data_i(ob), .in_buf_rd_i(ib_rd), .in_buf_data_o(ib), .irq_en_i(irq_en),
		.in_irq_o(in_irq), .out_irq_o(out_irq), .input_full_o(d_full),
		.output_empty_o(d_empty), .status_o(status));
	hbp_host hbp_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .pins(hbp_pins_if_i),
		.proto_i(proto), .strobe_level_i(lvl), .cmd_valid_i(cv), .cmd_ready_o(rdy),
		.cmd_write_i(cw), .cmd_status_i(cs), .cmd_byte_sel_i(cb), .cmd_data_i(cd),
		.rsp_valid_o(rv), .rsp_data_o(rd), .input_full_o(h_full), .output_empty_o(h_empty));
	hbp_link_props hbp_link_props_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.port_select_n(hbp_pins_if_i.port_select_n),
		.input_strobe_n(hbp_pins_if_i.input_strobe_n),
		.output_strobe_n(hbp_pins_if_i.output_strobe_n),
		.byte_select_pin(hbp_pins_if_i.byte_select_pin),
		.host_data_from_host(hbp_pins_if_i.host_data_from_host),
		.host_data_host_oe(hbp_pins_if_i.host_data_host_oe),
		.host_data_dev_oe(hbp_pins_if_i.host_data_dev_oe),
		.input_full_pin(hbp_pins_if_i.input_full_pin),
		.output_empty_pin(hbp_pins_if_i.output_empty_pin));

	always #25 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
		if (in_irq === 1'b1 || out_irq === 1'b1)
			n_irq++;

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function automatic logic [7:0] exp_stat(input logic f, input logic e, input logic inv);
		return {6'h00, f, e ^ inv};
	endfunction

	task give_verdict();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task core(input logic [7:0] c);
		@(posedge sys_clk_i);
		ctl_wr <= 1'b1;
		ctl <= c;
		proto <= c[1];
		lvl <= c[2];
		@(posedge sys_clk_i);
		ctl_wr <= 1'b0;
		tick(2);
	endtask
	task core_io(input logic wr);
		@(posedge sys_clk_i);
		ob_wr <= wr;
		ib_rd <= !wr;
		ob <= {rnd(), rnd()};
		@(posedge sys_clk_i);
		ob_wr <= 1'b0;
		ib_rd <= 1'b0;
		tick(1);
	endtask
	task wait_ready();
		int k;
		k = 0;
		do
		begin
			@(negedge sys_clk_i);
			if (rv === 1'b1)
				seen = 1'b1;
			k++;
		end
		while (rdy !== 1'b1 && k < 40);
		if (k >= 40)
		begin
			$display("wrong value cmd_ready_o expected 1 seen timeout");
			n_errors++;
			give_verdict();
		end
	endtask
	task host(input logic w, input logic s, input logic b, input logic [7:0] d);
		wait_ready();
		@(posedge sys_clk_i);
		cv <= 1'b1;
		cw <= w;
		cs <= s;
		cb <= b;
		cd <= d;
		@(posedge sys_clk_i);
		cv <= 1'b0;
		seen = 1'b0;
		wait_ready();
		if (!w)
			chk("rsp_valid_o", 16'h0001, {15'h0000, seen});
		tick(6);
	endtask

	initial
	begin
		tick(6);
		reset_i <= 1'b0;
		tick(4);
		@(negedge sys_clk_i);
		chk("ctrl_o", 16'h0000, {8'h00, ctrl_o});
		chk("status_o", {8'h00, exp_stat(1'b0, 1'b1, 1'b0)}, {8'h00, status});
		chk("host output_empty_o", 16'h0001, {15'h0000, h_empty});
		for (int i = 0; i < 8; i++)
		begin
			core({4'h0, i[0], i[2], i[1], 1'b1});
			chk("ctrl_o", {8'h00, 4'h0, i[0], i[2], i[1], 1'b1}, {8'h00, ctrl_o});
			irq_en <= {2{i[1]}};
			n_irq = 0;
			lo = rnd();
			hi = rnd();
			host(1'b1, 1'b0, 1'b0, i[0] ? hi : lo);
			chk("input_full_o", 16'h0000, {15'h0000, d_full});
			host(1'b1, 1'b0, 1'b1, i[0] ? lo : hi);
			chk("input_full_o", 16'h0001, {15'h0000, d_full});
			chk("in_buf_data_o", {hi, lo}, ib);
			chk("status_o", {8'h00, exp_stat(1'b1, 1'b1, 1'b0)}, {8'h00, status});
			chk("input_full_pin", 16'h0001, {15'h0000, hbp_pins_if_i.input_full_pin});
			chk("host input_full_o", 16'h0001, {15'h0000, h_full});
			host(1'b0, 1'b1, i[0], 8'h00);
			chk("status read 16", {8'h00, exp_stat(1'b1, 1'b1, 1'b0)}, {8'h00, rd});
			core_io(1'b0);
			chk("input_full_o", 16'h0000, {15'h0000, d_full});
			core_io(1'b1);
			chk("output_empty_o", 16'h0000, {15'h0000, d_empty});
			host(1'b0, 1'b0, 1'b0, 8'h00);
			chk("rsp_data_o", {8'h00, i[0] ? ob[15:8] : ob[7:0]}, {8'h00, rd});
			chk("output_empty_o", 16'h0000, {15'h0000, d_empty});
			host(1'b0, 1'b0, 1'b1, 8'h00);
			chk("rsp_data_o", {8'h00, i[0] ? ob[7:0] : ob[15:8]}, {8'h00, rd});
			chk("output_empty_pin", 16'h0001, {15'h0000, hbp_pins_if_i.output_empty_pin});
			chk("interrupt count", i[1] ? 16'h0005 : 16'h0000, n_irq[15:0]);
		end
		for (int i = 0; i < 4; i++)
		begin
			core({i[1], 3'h0, i[0], 3'h0});
			lo = rnd();
			host(1'b1, 1'b0, !i[0], lo);
			chk("input_full_o", 16'h0000, {15'h0000, d_full});
			host(1'b1, 1'b0, i[0], lo);
			chk("input_full_o", 16'h0001, {15'h0000, d_full});
			chk("in_buf_data_o low", {8'h00, lo}, {8'h00, ib[7:0]});
			host(1'b0, 1'b1, i[0], 8'h00);
			chk("status read", {8'h00, exp_stat(1'b1, 1'b1, i[1])}, {8'h00, rd});
			chk("output_empty_pin", 16'h0001, {15'h0000, hbp_pins_if_i.output_empty_pin});
			host(1'b0, 1'b1, !i[0], 8'h00);
			chk("reserved read", 16'h00FF, {8'h00, rd});
			core_io(1'b1);
			host(1'b0, 1'b0, i[0], 8'h00);
			chk("rsp_data_o", {8'h00, ob[7:0]}, {8'h00, rd});
			chk("output_empty_o", 16'h0001, {15'h0000, d_empty});
			core_io(1'b0);
		end
		core(8'h10);
		chk("inverted pins", 16'h0002, {14'h0000, hbp_pins_if_i.input_full_pin,
			hbp_pins_if_i.output_empty_pin});
		core(8'h20);
		chk("merged full pin", 16'h0001, {15'h0000, hbp_pins_if_i.input_full_pin});
		give_verdict();
	end
endmodule
